// *** rtl/dpc_regs.sv ***
// Purpose: record area base, channel pointer window and command/state register
// Assumes: AHB-Lite slave, single transfers, engine drives xfer_busy and requests
// Notes:   window reads insert one wait state for the pointer store read
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1: record address is base plus record offset, handed to the engine.
// RQ2: software writes zero to base bits 1:0.
// RQ3: software keeps records within 16 KB of base, in read-write memory.
// RQ4: software never programs base above 0xFFFFFFF0.
// RQ5: base set at initialisation; writes ignored while a transfer executes.
// RQ6: channel pointer window works only in the normal state; outside it, window reads still return the channel select.
// RQ7: byte write selects channel; halfword at bits 29:16 reads/writes pointer.
// RQ8: word write updates channel select and pointer together.
// RQ9: software writes zero to unused upper channel-select bits.
// RQ10: software keeps pointers word aligned and at most 0x3FF0.
// RQ11: pointer cached before use and reused for repeated requests.
// RQ12: changing read-skip-disable invalidates the pointer cache.
// RQ13: command register takes byte writes only; wider writes ignored.
// RQ14: command 0x04 starts standby to normal.
// RQ15: command 0x08 enters standby, clears done flags, sets all masks.
// RQ16: command 0x10 clears software-done flag and its interrupt.
// RQ17: command 0x20 clears error code, record pointer, stop flag, interrupt.
// RQ18: command 0x80 clears masks, ignored in normal-to-standby transition.
// RQ19: other command values are ignored.
// RQ20: reading command register returns state code 0..3, reset standby.
// RQ21: standby entry during a transfer forces it to end first.
// RQ22: window writes outside normal state are discarded.
module dpc_regs
    import dpc_pkg::*;
#(
    parameter int CH_NUM = 256
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic      [31:0]          hrdata,
    input  wire logic                 xfer_busy,
    input  wire logic [PTR_W-1:0]     rec_offset,
    output logic      [31:0]          rec_addr,
    output logic                      abort_req,
    input  wire logic                 hw_req,
    input  wire logic [CHAN_W-1:0]    hw_req_chan,
    output logic                      hw_ptr_vld,
    output logic      [PTR_W-1:0]     hw_ptr,
    output logic                      clr_sw_done,
    output logic                      clr_hw_done,
    output logic                      clr_error,
    output logic                      set_masks,
    output logic                      clr_masks,
    output logic      [1:0]           state_code,
    output logic                      read_skip_disable
);

    localparam int AW = $clog2(CH_NUM);

    if (CH_NUM < 2 || CH_NUM > 256 || (CH_NUM & (CH_NUM - 1)) != 0)
    begin : g_bad_ch_num
        $error("CH_NUM must be a power of two from 2 to 256");
    end

    // byte enables of an AHB transfer
    function automatic logic [3:0] be_f(input logic [2:0] sz, input logic [1:0] lo);
        logic [3:0] be;
        be = 4'h0;
        if (sz == HSIZE_BYTE)
            be = 4'b0001 << lo;
        else if (sz == HSIZE_HALF)
            be = lo[1] ? 4'b1100 : 4'b0011;
        else if (sz == HSIZE_WORD)
            be = 4'b1111;
        return be;
    endfunction : be_f

    function automatic logic [7:0] code_f(input dpc_state_t st);
        logic [7:0] c;
        c = RD_STANDBY;
        unique case (st)
            ST_NORMAL:  c = RD_NORMAL;
            ST_STANDBY: c = RD_STANDBY;
            ST_WAKE:    c = RD_WAKE;
            ST_SLEEP:   c = RD_SLEEP;
        endcase
        return c;
    endfunction : code_f

    logic              a_vld_r;
    logic              a_wr_r;
    logic [7:0]        a_word_r;
    logic [1:0]        a_lo_r;
    logic [2:0]        a_size_r;
    logic              hready_r;
    logic [3:0]        be;
    logic              wr_go;
    logic              hit_base;
    logic              hit_win;
    logic              hit_cmd;
    logic              hit_cfg;
    logic              cmd_go;
    logic              cfg_go;
    logic              rsd_chg;
    logic [7:0]        cmd_val;
    logic [31:0]       base_r;
    logic [31:0]       rec_addr_r;
    logic [CHAN_W-1:0] chan_sel_r;
    logic              rsd_r;
    logic              ptr_we;
    logic [PTR_W-1:0]  mem_a_q;
    logic [PTR_W-1:0]  mem_b_q;
    logic [AW-1:0]     mem_b_addr;
    logic [AW-1:0]     ptr_waddr;
    logic [7:0]        state_rd;
    logic [1:0]        wake_cnt_r;
    logic              sleep_go;
    dpc_state_t        state_r;

    // ========================================================================
    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_vld_r  <= 1'b0;
            a_wr_r   <= 1'b0;
            a_word_r <= 8'h00;
            a_lo_r   <= 2'b00;
            a_size_r <= HSIZE_BYTE;
        end
        else if (hready)
        begin
            a_vld_r  <= hsel && htrans[1];
            a_wr_r   <= hwrite;
            a_word_r <= haddr[9:2];
            a_lo_r   <= haddr[1:0];
            a_size_r <= hsize;
        end
    end

    // one wait state on window reads so the store's registered read lands
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hready_r <= 1'b1;
        else if (hready && hsel && htrans[1] && !hwrite && haddr[9:2] == IDX_WIN)
            hready_r <= 1'b0;
        else
            hready_r <= 1'b1;
    end

    assign hreadyout = hready_r;
    assign hresp     = 1'b0;

    // data phase decode
    assign be       = be_f(a_size_r, a_lo_r);
    assign wr_go    = a_vld_r && a_wr_r && hready;
    assign hit_base = a_word_r == IDX_BASE;
    assign hit_win  = a_word_r == IDX_WIN;
    assign hit_cmd  = a_word_r == IDX_CMD;
    assign hit_cfg  = a_word_r == IDX_CFG;
    assign cmd_val  = hwdata[7:0];
    assign cmd_go   = wr_go && hit_cmd && be == 4'b0001 && a_size_r == HSIZE_BYTE; // [RQ13]
    assign cfg_go   = wr_go && hit_cfg && be == 4'b0001 && a_size_r == HSIZE_BYTE;
    assign rsd_chg  = cfg_go && (hwdata[CFG_RSD_BIT] != rsd_r);
    assign sleep_go = cmd_go && cmd_val == CMD_SLEEP && state_r == ST_NORMAL;

    // read mux; unmapped words read zero
    always_comb
    begin
        hrdata = 32'h0;
        if (a_vld_r && !a_wr_r)
        begin
            if (hit_base)
                hrdata = base_r;
            else if (hit_win && state_r == ST_NORMAL)           // [RQ6]
                hrdata = {2'b00, mem_a_q, 8'h00, chan_sel_r};   // [RQ7]
            else if (hit_win)
                hrdata = {24'h0, chan_sel_r};
            else if (hit_cmd)
                hrdata = {24'h0, state_rd};                     // [RQ20]
            else if (hit_cfg)
                hrdata = {29'h0, rsd_r, 2'b00};
        end
    end

    // ========================================================================
    // record area base; frozen while the engine moves data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            base_r <= BASE_RST;
        else if (wr_go && hit_base && !xfer_busy)               // [RQ5]
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (be[i])
                    base_r[8*i +: 8] <= hwdata[8*i +: 8];
            end
        end
    end

    // record address, registered so the engine sees a clean sum
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rec_addr_r <= BASE_RST;
        else
            rec_addr_r <= base_r + {18'h0, rec_offset};         // [RQ1]
    end

    assign rec_addr = rec_addr_r;

    // ========================================================================
    // channel pointer window; locked outside the normal state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            chan_sel_r <= CHAN_RST;
        else if (wr_go && hit_win && state_r == ST_NORMAL && be[0]) // [RQ22]
            chan_sel_r <= hwdata[CHAN_W-1:0];                   // [RQ7] [RQ8]
    end

    assign ptr_we = wr_go && hit_win && state_r == ST_NORMAL && be[2] && be[3]; // [RQ8]

    // a word write lands on the channel it selects, not the previous one
    assign ptr_waddr = be[0] ? hwdata[AW-1:0] : chan_sel_r[AW-1:0];         // [RQ8]

    dpc_ptr_mem #(
        .DEPTH (CH_NUM),
        .AW    (AW),
        .DW    (PTR_W)
    ) u_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .we      (ptr_we),
        .waddr   (ptr_waddr),
        .wdata   (hwdata[WIN_PTR_LSB +: PTR_W]),
        .raddr_a (chan_sel_r[AW-1:0]),
        .rdata_a (mem_a_q),
        .raddr_b (mem_b_addr),
        .rdata_b (mem_b_q)
    );

    // read-skip-disable; any change drops the cached pointer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rsd_r <= RSD_RST;
        else if (cfg_go)
            rsd_r <= hwdata[CFG_RSD_BIT];
    end

    assign read_skip_disable = rsd_r;

    dpc_ptr_cache #(
        .AW (AW)
    ) u_cache (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .req        (hw_req),
        .req_chan   (hw_req_chan[AW-1:0]),
        .bypass     (rsd_r),
        .invalidate (rsd_chg),                                  // [RQ12]
        .mem_addr   (mem_b_addr),
        .mem_data   (mem_b_q),
        .ptr_vld    (hw_ptr_vld),
        .ptr        (hw_ptr)
    );

    // ========================================================================
    // operating state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_r <= ST_STANDBY;
        else
        begin
            unique case (state_r)
                ST_STANDBY:
                    if (cmd_go && cmd_val == CMD_WAKE)
                        state_r <= ST_WAKE;                     // [RQ14]
                ST_WAKE:
                    if (wake_cnt_r == WAKE_CYCLES - 2'd1)
                        state_r <= ST_NORMAL;
                ST_NORMAL:
                    if (sleep_go)
                        state_r <= ST_SLEEP;                    // [RQ15]
                ST_SLEEP:
                    if (!xfer_busy)
                        state_r <= ST_STANDBY;                  // [RQ21]
            endcase
        end
    end

    // wake settle counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wake_cnt_r <= 2'd0;
        else if (state_r == ST_WAKE)
            wake_cnt_r <= wake_cnt_r + 2'd1;
        else
            wake_cnt_r <= 2'd0;
    end

    // engine must cut the running transfer and close its record
    assign abort_req  = state_r == ST_SLEEP && xfer_busy;      // [RQ21]
    assign state_rd   = code_f(state_r);
    assign state_code = state_rd[1:0];

    // command side effects, one-cycle pulses; unknown codes do nothing [RQ19]
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clr_sw_done <= 1'b0;
            clr_hw_done <= 1'b0;
            clr_error   <= 1'b0;
            set_masks   <= 1'b0;
            clr_masks   <= 1'b0;
        end
        else
        begin
            clr_sw_done <= sleep_go || (cmd_go && cmd_val == CMD_CLEAR_SW_DONE_CMD); // [RQ15] [RQ16]
            clr_hw_done <= sleep_go;                                     // [RQ15]
            set_masks   <= sleep_go;                                     // [RQ15]
            clr_error   <= cmd_go && cmd_val == CMD_CLEAR_ERROR_CMD;               // [RQ17]
            clr_masks   <= cmd_go && cmd_val == CMD_CLEAR_MASKS_CMD && state_r != ST_SLEEP; // [RQ18]
        end
    end

    // ========================================================================
    // checks
    AST_REC_ADDR: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ1]
        1'b1 |=> rec_addr_r == $past(base_r) + {18'h0, $past(rec_offset)})
        else $error("record address is not base plus offset");

    AST_BASE_FROZEN: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ5]
        xfer_busy |=> $stable(base_r))
        else $error("base changed during a transfer");

    AST_WIN_LOCKED: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ22]
        (state_r != ST_NORMAL) |-> !ptr_we ##1 $stable(chan_sel_r))
        else $error("window written outside normal state");

    AST_WORD_BOTH: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ8]
        (wr_go && hit_win && be == 4'b1111 && state_r == ST_NORMAL)
        |-> ptr_we && ptr_waddr == hwdata[AW-1:0] ##1 chan_sel_r == $past(hwdata[CHAN_W-1:0]))
        else $error("word write did not update select and pointer");

    AST_CMD_BYTE_ONLY: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ13]
        (wr_go && hit_cmd && a_size_r != HSIZE_BYTE)
        |=> !(clr_sw_done || clr_error || clr_masks || set_masks))
        else $error("wide write to command register acted");

    AST_WAKE: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ14]
        (cmd_go && cmd_val == CMD_WAKE && state_r == ST_STANDBY)
        |=> (state_r == ST_WAKE)[*3] ##1 state_r == ST_NORMAL)
        else $error("standby release sequence wrong");

    AST_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ15]
        sleep_go |=> state_r == ST_SLEEP && clr_sw_done && clr_hw_done && set_masks)
        else $error("standby entry effects missing");

    AST_CLEAR_SW_DONE_CMD: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ16]
        (cmd_go && cmd_val == CMD_CLEAR_SW_DONE_CMD) |=> clr_sw_done && !clr_error)
        else $error("software-done clear not issued");

    AST_CLEAR_ERROR_CMD: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ17]
        (cmd_go && cmd_val == CMD_CLEAR_ERROR_CMD) |=> clr_error && !clr_sw_done)
        else $error("error clear not issued");

    AST_CLEAR_MASKS_CMD_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ18]
        (cmd_go && cmd_val == CMD_CLEAR_MASKS_CMD) |=> clr_masks == ($past(state_r) != ST_SLEEP))
        else $error("mask clear wrong for state");

    AST_STATE_READ: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ20]
        (a_vld_r && !a_wr_r && hit_cmd) |-> hrdata[31:2] == 30'h0)
        else $error("command register read out of range");

    AST_SLEEP_WAIT: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ21]
        (state_r == ST_SLEEP && xfer_busy) |-> abort_req ##1 state_r == ST_SLEEP)
        else $error("standby entered while transfer running");

endmodule : dpc_regs
`default_nettype wire

// *** rtl/dpc_pkg.sv ***
// Purpose: shared constants and types of the record pointer and command front end
// Assumes: AHB-Lite register access, one clock
// Notes:   byte address of each register is its index times four
package dpc_pkg;

    // ========================================================================
    // register indices (byte address = index * 4)
    localparam logic [7:0] IDX_BASE = 8'h00;
    localparam logic [7:0] IDX_WIN  = 8'h04;
    localparam logic [7:0] IDX_CMD  = 8'h08;
    localparam logic [7:0] IDX_CFG  = 8'h09;

    // ========================================================================
    // field layout
    localparam int         PTR_W       = 14;
    localparam int         CHAN_W      = 8;
    localparam int         WIN_PTR_LSB = 16;
    localparam int         CFG_RSD_BIT = 2;

    // ========================================================================
    // values after reset
    localparam logic [31:0] BASE_RST = 32'h0000_0000;
    localparam logic [7:0]  CHAN_RST = 8'h00;
    localparam logic        RSD_RST  = 1'b0;

    // ========================================================================
    // command codes
    localparam logic [7:0] CMD_WAKE  = 8'h04;
    localparam logic [7:0] CMD_SLEEP = 8'h08;
    localparam logic [7:0] CMD_CLEAR_SW_DONE_CMD = 8'h10;
    localparam logic [7:0] CMD_CLEAR_ERROR_CMD = 8'h20;
    localparam logic [7:0] CMD_CLEAR_MASKS_CMD = 8'h80;

    // ========================================================================
    // state codes as read back
    localparam logic [7:0] RD_NORMAL  = 8'h00;
    localparam logic [7:0] RD_STANDBY = 8'h01;
    localparam logic [7:0] RD_WAKE    = 8'h02;
    localparam logic [7:0] RD_SLEEP   = 8'h03;

    // ========================================================================
    // timing and bus encodings
    localparam logic [1:0] WAKE_CYCLES = 2'd3;
    localparam logic [2:0] HSIZE_BYTE  = 3'b000;
    localparam logic [2:0] HSIZE_HALF  = 3'b001;
    localparam logic [2:0] HSIZE_WORD  = 3'b010;

    // gray along standby -> wake -> normal -> sleep -> standby
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_WAKE    = 2'b01,
        ST_NORMAL  = 2'b11,
        ST_SLEEP   = 2'b10
    } dpc_state_t;

endpackage : dpc_pkg

// *** rtl/dpc_ptr_mem.sv ***
// Purpose: per-channel record pointer store, one write and two read ports
// Assumes: single clock, read data registered
// Notes:   array holds no reset; pointers are undefined until written
`timescale 1ns/1ps
`default_nettype none
module dpc_ptr_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8,
    parameter int DW    = 14
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [DW-1:0] rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_b
);

    logic [DW-1:0] mem_r [DEPTH];

    // ========================================================================
    // storage, no reset so it maps onto plain ram
    always_ff @(posedge hclk)
    begin
        if (we)
        begin
            mem_r[waddr] <= wdata;
        end
    end

    // registered reads; a same-cycle write is seen one cycle later
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_a <= '0;
            rdata_b <= '0;
        end
        else
        begin
            rdata_a <= mem_r[raddr_a];
            rdata_b <= mem_r[raddr_b];
        end
    end

endmodule : dpc_ptr_mem
`default_nettype wire

// *** rtl/dpc_ptr_cache.sv ***
// Purpose: one-entry cache of the last hardware channel pointer used
// Assumes: one request outstanding at a time
// Notes:   miss answers in two cycles, hit in one
`timescale 1ns/1ps
`default_nettype none
module dpc_ptr_cache
    import dpc_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             req,
    input  wire logic [AW-1:0]    req_chan,
    input  wire logic             bypass,
    input  wire logic             invalidate,
    output logic      [AW-1:0]    mem_addr,
    input  wire logic [PTR_W-1:0] mem_data,
    output logic                  ptr_vld,
    output logic      [PTR_W-1:0] ptr
);

    logic             cvld_r;
    logic [AW-1:0]    cchan_r;
    logic [PTR_W-1:0] cptr_r;
    logic             pend_r;
    logic             hit;

    // ========================================================================
    // lookup
    assign mem_addr = req_chan;
    assign hit      = req && !pend_r && cvld_r && !bypass && (cchan_r == req_chan);

    // answer from cache or from the store one cycle after the miss
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_r  <= 1'b0;
            ptr_vld <= 1'b0;
            ptr     <= '0;
        end
        else
        begin
            ptr_vld <= 1'b0;
            if (pend_r)
            begin
                pend_r  <= 1'b0;
                ptr_vld <= 1'b1;
                ptr     <= mem_data;            // [RQ11]
            end
            else if (hit)
            begin
                ptr_vld <= 1'b1;
                ptr     <= cptr_r;              // [RQ11]
            end
            else if (req)
            begin
                pend_r <= 1'b1;
            end
        end
    end

    // fill on miss; invalidate wins since the fetched copy may be stale
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cvld_r  <= 1'b0;
            cptr_r  <= '0;
        end
        else if (invalidate)
        begin
            cvld_r <= 1'b0;                     // [RQ12]
        end
        else if (pend_r && !bypass)
        begin
            cvld_r <= 1'b1;                     // [RQ11]
            cptr_r <= mem_data;
        end
    end

    // tag follows every miss, even one meeting an invalidate, so a fill never pairs a stale tag
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cchan_r <= '0;
        else if (req && !pend_r && !hit)
            cchan_r <= req_chan;                // [RQ11]
    end

    // ========================================================================
    // checks
    AST_ANSWER_TIME: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ11]
        (req && !pend_r) |-> ##[1:2] ptr_vld)
        else $error("pointer request not answered within two cycles");

    AST_INVALIDATE: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ12]
        invalidate |=> !cvld_r)
        else $error("pointer cache still valid after invalidate");

endmodule : dpc_ptr_cache
`default_nettype wire

// *** test/dpc_regs_tb.sv ***
// Purpose: self-checking bench for the record pointer and command front end
// Assumes: one AHB-Lite master, single slave, hready looped from hreadyout
// Notes:   pulse outputs are gathered at the falling edge
`timescale 1ns/1ps
`default_nettype none
module dpc_regs_tb;
    import dpc_pkg::*;
    logic        hclk, hresetn, hwrite, xfer_busy, hw_req, hreadyout, hw_ptr_vld, abort_req;
    logic        clr_sw_done, clr_hw_done, clr_error, set_masks, clr_masks;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rec_addr, q;
    logic [13:0] rec_offset, hw_ptr;
    logic [7:0]  hw_req_chan;
    logic [4:0]  seen;
    int          error_cnt, checks_done;

    dpc_regs DUT (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .xfer_busy, .rec_offset,
        .rec_addr, .abort_req, .hw_req, .hw_req_chan, .hw_ptr_vld, .hw_ptr,
        .clr_sw_done, .clr_hw_done, .clr_error, .set_masks, .clr_masks,
        .state_code(), .read_skip_disable()
    );

    // ========================================================================
    // clock generator
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ========================================================================
    // tasks
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask : chk

    // bounded wait for hready, a hang ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [9:0] a, input logic [2:0] s,
                       input logic [31:0] d);
        htrans <= 2'b10;
        haddr  <= {22'h0, a};
        hwrite <= w;
        hsize  <= s;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : bus

    task automatic st(input logic [7:0] e);
        bus(1'b0, 10'h20, HSIZE_BYTE, 32'h0);
        chk("state", {24'h0, q[7:0]}, {24'h0, e});
    endtask : st

    task automatic cmd(input logic [7:0] c, input logic [4:0] e);
        bus(1'b1, 10'h20, HSIZE_BYTE, {24'h0, c});
        // pulses last one cycle, so sample them away from the rising edge
        @(negedge hclk);
        seen = {clr_sw_done, clr_hw_done, clr_error, set_masks, clr_masks};
        @(posedge hclk);
        chk("pulses", {27'h0, seen}, {27'h0, e});
    endtask : cmd

    task automatic hwreq(input logic [7:0] ch, input logic [13:0] e);
        hw_req      <= 1'b1;
        hw_req_chan <= ch;
        @(posedge hclk);
        hw_req <= 1'b0;
        repeat (4)
        begin
            @(posedge hclk);
            if (hw_ptr_vld === 1'b1)
                break;
        end
        chk("hw_ptr", {17'h0, hw_ptr_vld, hw_ptr}, {17'h0, 1'b1, e});
    endtask : hwreq

    // ========================================================================
    // main sequence
    initial
    begin
        {hresetn, hwrite, xfer_busy, hw_req, htrans, hsize, haddr, hwdata, rec_offset,
         hw_req_chan, error_cnt, checks_done, seen} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        st(RD_STANDBY);
        bus(1'b1, 10'h10, HSIZE_WORD, 32'h0040_0005);
        bus(1'b1, 10'h20, HSIZE_WORD, 32'h4);
        st(RD_STANDBY);
        bus(1'b1, 10'h20, HSIZE_BYTE, 32'h44);
        st(RD_STANDBY);
        bus(1'b1, 10'h20, HSIZE_BYTE, {24'h0, CMD_WAKE});
        st(RD_WAKE);
        repeat (5) @(posedge hclk);
        st(RD_NORMAL);
        bus(1'b0, 10'h10, HSIZE_WORD, 32'h0);
        chk("select", q & 32'hff, 32'h0);
        bus(1'b1, 10'h10, HSIZE_BYTE, 32'h3);
        bus(1'b1, 10'h12, HSIZE_HALF, 32'h0124_0000);
        bus(1'b1, 10'h10, HSIZE_WORD, 32'h0200_0007);
        bus(1'b0, 10'h10, HSIZE_WORD, 32'h0);
        chk("window", q, 32'h0200_0007);
        bus(1'b1, 10'h10, HSIZE_BYTE, 32'h3);
        bus(1'b0, 10'h12, HSIZE_HALF, 32'h0);
        chk("window", q, 32'h0124_0003);
        hwreq(8'h3, 14'h124);
        bus(1'b1, 10'h10, HSIZE_WORD, 32'h0300_0003);
        hwreq(8'h3, 14'h124);
        bus(1'b1, 10'h24, HSIZE_BYTE, 32'h4);
        hwreq(8'h3, 14'h300);
        // base plus offset, then a write refused while busy
        rec_offset <= 14'h0010;
        bus(1'b1, 10'h00, HSIZE_WORD, 32'h2000_0100);
        bus(1'b0, 10'h00, HSIZE_WORD, 32'h0);
        chk("rec_addr", rec_addr, 32'h2000_0110);
        xfer_busy <= 1'b1;
        bus(1'b1, 10'h00, HSIZE_WORD, 32'h0000_0400);
        bus(1'b0, 10'h00, HSIZE_WORD, 32'h0);
        chk("base", q, 32'h2000_0100);
        cmd(CMD_CLEAR_SW_DONE_CMD, 5'b10000);
        cmd(CMD_CLEAR_ERROR_CMD, 5'b00100);
        cmd(CMD_CLEAR_MASKS_CMD, 5'b00001);
        cmd(CMD_SLEEP, 5'b11010);
        st(RD_SLEEP);
        chk("abort", {31'h0, abort_req}, 32'h1);
        cmd(CMD_CLEAR_MASKS_CMD, 5'b00000);
        xfer_busy <= 1'b0;
        repeat (3) @(posedge hclk);
        st(RD_STANDBY);
        wrap_up();
    end
endmodule : dpc_regs_tb
`default_nettype wire
